/* hdl/hvp_ddr_source.sv */
// Source side of a four-bus DDR sample port with strobe generation
// Overview of operation
// - Each bus sends its own forwarded clock
// - Earlier samples on lower-lettered buses
// - Two-bus mode: A,B channel A; C,D B
// - One-bus mode: only A and C active
// - Single-channel mode uses all four buses
// - Strobe period multiple of four bus clocks
// - Strobe sent with rising-edge data word
// - Hold LSB zero during role changeover
// - Dedicated strobes low in LSB mode
// - Select pin high under register control
// - All bus strobes launched together
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
module hvp_ddr_source
	import hvp_pkg::*;
(
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	input  wire logic [ADDR_W-1:0]           i_addr,
	input  wire logic [DATA_W-1:0]           i_wdata,
	input  wire logic                        i_we,
	input  wire logic                        i_re,
	output logic      [DATA_W-1:0]           o_rdata,
	input  wire logic                        i_smp_valid,
	input  wire logic [NUM_BUS*WORD_W-1:0]   i_smp_data,
	output logic                             o_smp_ready,
	output logic      [NUM_BUS-1:0]          o_bus_clk,
	output logic      [NUM_BUS*WORD_W-1:0]   o_bus_data,
	output logic      [NUM_BUS-1:0]          o_bus_strobe,
	output logic                             o_sync_n
);
	hvp_tick_if tick_bus ();

	logic                     ctrl_run;
	logic [1:0]               ctrl_mode;
	logic                     ctrl_lsb_req;
	logic                     ctrl_reg_sel;
	logic [3:0]               ctrl_res;
	logic [7:0]               period;
	logic                     underrun;
	hvp_state_type            state;
	hvp_state_type            next_state;
	logic                     phase;
	logic                     lsb_act;
	logic [NUM_BUS-1:0]       bus_en;
	logic [9:0]               strb_cnt;
	logic [2:0]               guard_cnt;
	logic                     rise_launch;
	logic                     strobe_now;
	logic                     streaming;
	logic [3:0]               lsb_idx;
	logic [WORD_W-1:0]        slot [NUM_BUS];
	logic [WORD_W-1:0]        word [NUM_BUS];
	logic                     reg_wr;
	logic                     wr_ctrl;
	logic                     wr_period;
	logic                     clr_underrun;
	logic                     taking;

	hvp_ddr_tick u_tick (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.tk    (tick_bus)
	);

	assign rise_launch = tick_bus.launch & ~phase;
	assign streaming   = (state != ST_IDLE);
	assign lsb_idx     = lsb_index(ctrl_res);
	assign reg_wr      = i_we;
	assign wr_ctrl     = reg_wr && (i_addr == REG_CTRL);
	assign wr_period   = reg_wr && (i_addr == REG_PERIOD);
	assign clr_underrun = reg_wr && (i_addr == REG_STATUS) && i_wdata[0];

	// Stopping launch takes no group; its word is never clocked out
	assign taking      = tick_bus.launch & streaming & (bus_en != '0)
		& ~(rise_launch & (next_state == ST_IDLE));

	// Control register writes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_run     <= 1'b0;
			ctrl_mode    <= 2'h0;
			ctrl_lsb_req <= 1'b0;
			ctrl_reg_sel <= 1'b0;
			ctrl_res     <= RES_RESET;
		end else if (wr_ctrl) begin
			ctrl_run     <= i_wdata[CTRL_RUN_BIT];
			ctrl_mode    <= i_wdata[CTRL_MODE_LSB +: 2];
			ctrl_lsb_req <= i_wdata[CTRL_LSB_BIT];
			ctrl_reg_sel <= i_wdata[CTRL_RSEL_BIT];
			ctrl_res     <= i_wdata[CTRL_RES_LSB +: 4];
		end
	end

	// Strobe period register writes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			period <= PERIOD_RESET;
		end else if (wr_period) begin
			period <= i_wdata[7:0];
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= '0;
		end else if (i_re) begin
			unique case (i_addr)
				REG_CTRL:   o_rdata <= {20'h0_0000, ctrl_res, 3'h0, ctrl_reg_sel,
				                        ctrl_lsb_req, ctrl_mode, ctrl_run};
				REG_PERIOD: o_rdata <= {24'h00_0000, period};
				REG_STATUS: o_rdata <= {24'h00_0000, bus_en, ctrl_run & (state == ST_RUN),
				                        lsb_act, (state == ST_GUARD), underrun};
				default:    o_rdata <= '0;
			endcase
		end else begin
			o_rdata <= '0;
		end
	end

	// Word position within the bus clock period
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			phase <= 1'b0;
		end else if (tick_bus.launch) begin
			phase <= ~phase;
		end
	end

	// Bus enables and LSB role change only at a rising-word launch
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (ctrl_run) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!ctrl_run) begin
					next_state = ST_IDLE;
				end else if (ctrl_lsb_req != lsb_act) begin
					next_state = ST_GUARD;
				end
			end
			ST_GUARD: begin
				if (guard_cnt == 3'h0) begin
					next_state = ST_RUN;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
		end else if (rise_launch) begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			guard_cnt <= 3'h0;
		end else if (rise_launch) begin
			if (state == ST_RUN && next_state == ST_GUARD) begin
				guard_cnt <= GUARD_CLKS - 3'h1;
			end else if (state == ST_GUARD && guard_cnt != 3'h0) begin
				guard_cnt <= guard_cnt - 3'h1;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lsb_act <= 1'b0;
		end else if (rise_launch) begin
			if (state == ST_IDLE || (state == ST_GUARD && guard_cnt == 3'h0)) begin
				lsb_act <= ctrl_lsb_req;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bus_en <= '0;
		end else if (rise_launch) begin
			bus_en <= (next_state == ST_IDLE) ? '0 : bus_enable(ctrl_mode);
		end
	end

	// Select pin: tied high when the register bit moves the LSB role
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_sync_n <= 1'b1;
		end else if (ctrl_reg_sel) begin
			o_sync_n <= 1'b1;
		end else begin
			o_sync_n <= ~((state == ST_GUARD) ? ctrl_lsb_req : lsb_act);
		end
	end

	// Shared strobe counter keeps every bus strobe on the same word
	// No strobe on the launch that enters a changeover
	assign strobe_now = (state == ST_RUN) && (next_state == ST_RUN) && ~phase
		&& (period != 8'h00) && (strb_cnt == 10'h000);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			strb_cnt <= 10'h000;
		end else if (rise_launch) begin
			if (state != ST_RUN) begin
				strb_cnt <= 10'h000;
			end else if (strb_cnt == 10'h000) begin
				strb_cnt <= 10'({2'h0, period} * STRB_UNIT) - 10'h001;
			end else begin
				strb_cnt <= strb_cnt - 10'h001;
			end
		end
	end

	// Sample group taken at each launch while streaming with a bus enabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_smp_ready <= 1'b0;
		end else begin
			o_smp_ready <= taking & i_smp_valid;
		end
	end

	// Missing group is sent as zeros; a new underrun beats the clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			underrun <= 1'b0;
		end else begin
			underrun <= (underrun & ~clr_underrun) | (taking & ~i_smp_valid);
		end
	end

	// Slot to bus mapping, earliest sample on the lowest bus
	always_comb begin
		for (int s = 0; s < NUM_BUS; s++) begin
			slot[s] = i_smp_valid ? i_smp_data[s*WORD_W +: WORD_W] : '0;
		end
		for (int b = 0; b < NUM_BUS; b++) begin
			word[b] = slot[b];
		end
		if (ctrl_mode == 2'h1) begin
			word[0] = slot[0];
			word[1] = '0;
			word[2] = slot[1];
			word[3] = '0;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_BUS; g++) begin : g_lane
			hvp_bus_lane u_lane (
				.i_clk      (i_clk),
				.i_rst      (i_rst),
				.tk         (tick_bus),
				.i_en       (bus_en[g]),
				.i_word     (word[g]),
				.i_strobe   (strobe_now),
				.i_lsb_mode (lsb_act),
				.i_lsb_zero (state == ST_GUARD),
				.i_lsb_idx  (lsb_idx),
				.o_clk      (o_bus_clk[g]),
				.o_data     (o_bus_data[g*WORD_W +: WORD_W]),
				.o_strb     (o_bus_strobe[g])
			);
		end
	endgenerate

endmodule

/* hdl/hvp_pkg.sv */
// Shared constants, types and helpers for the DDR sample bus driver
package hvp_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int BUS_HALF_NS   = 80;
	localparam int BUS_HALF_CYC  = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUS_MID_CYC   = BUS_HALF_CYC / 2;
	localparam int DIV_W         = 8;

	localparam int NUM_BUS = 4;
	localparam int WORD_W  = 12;
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 32;

	localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] REG_PERIOD = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_LSB_BIT  = 3;
	localparam int CTRL_RSEL_BIT = 4;
	localparam int CTRL_RES_LSB  = 8;

	localparam logic [3:0]  RES_RESET    = 4'hc;
	localparam logic [7:0]  PERIOD_RESET = 8'h01;
	localparam logic [9:0]  STRB_UNIT    = 10'h004;
	localparam logic [2:0]  GUARD_CLKS   = 3'h4;

	typedef enum logic [1:0] {
		two_bus_per_channel_mode    = 2'h0,
		one_bus_per_channel_mode    = 2'h1,
		four_bus_single_channel_mode = 2'h2
	} hvp_mode_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_RUN   = 3'h2,
		ST_GUARD = 3'h4
	} hvp_state_type;

	// Buses driven in each mapping
	function automatic logic [NUM_BUS-1:0] bus_enable(input logic [1:0] mode);
		unique case (mode)
			2'h1:    bus_enable = 4'h5;
			2'h0,
			2'h2:    bus_enable = 4'hf;
			default: bus_enable = 4'h0;
		endcase
	endfunction

	// Data line carrying the strobe: twelve minus resolution
	function automatic logic [3:0] lsb_index(input logic [3:0] res);
		if (res == 4'h0 || res > 4'hc) begin
			lsb_index = 4'h0;
		end else begin
			lsb_index = 4'hc - res;
		end
	endfunction

endpackage

/* hdl/hvp_tick_if.sv */
// Launch and toggle pulses shared by the divider and the bus lanes
`timescale 1ns/1ps
interface hvp_tick_if;
	logic launch;
	logic toggle;
	modport src (output launch, output toggle);
	modport snk (input launch, input toggle);
endinterface

/* hdl/hvp_ddr_tick.sv */
// Divider making the forwarded bus clock timing from the system clock
`timescale 1ns/1ps
module hvp_ddr_tick
	import hvp_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	hvp_tick_if.src   tk
);
	logic [DIV_W-1:0] count;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= '0;
		end else if (count == DIV_W'(BUS_HALF_CYC - 1)) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// Data launches at the start of each half period, clock edge mid-eye
	assign tk.launch = (count == '0);
	assign tk.toggle = (count == DIV_W'(BUS_MID_CYC));

endmodule

/* hdl/hvp_bus_lane.sv */
// One 12-bit DDR bus with its forwarded clock and dedicated strobe
`timescale 1ns/1ps
module hvp_bus_lane
	import hvp_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	hvp_tick_if.snk                tk,
	input  wire logic              i_en,
	input  wire logic [WORD_W-1:0] i_word,
	input  wire logic              i_strobe,
	input  wire logic              i_lsb_mode,
	input  wire logic              i_lsb_zero,
	input  wire logic [3:0]        i_lsb_idx,
	output logic                   o_clk,
	output logic [WORD_W-1:0]      o_data,
	output logic                   o_strb
);
	logic [WORD_W-1:0] next_data;

	always_comb begin
		next_data = i_en ? i_word : '0;
		if (i_lsb_zero) begin
			next_data[i_lsb_idx] = 1'b0;
		end else if (i_lsb_mode) begin
			next_data[i_lsb_idx] = i_en & i_strobe;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_data <= '0;
			o_strb <= 1'b0;
		end else if (tk.launch) begin
			o_data <= next_data;
			o_strb <= i_en & i_strobe & ~i_lsb_mode & ~i_lsb_zero;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_clk <= 1'b0;
		end else if (tk.toggle) begin
			o_clk <= i_en & ~o_clk;
		end
	end

endmodule

/* sim/hvp_rx_model.sv */
// Converter-side model capturing four DDR buses on their own clocks
`timescale 1ns/1ps
module hvp_rx_model
	import hvp_pkg::*;
#(
	parameter int RES = 12
)
(
	input  wire logic                      i_rst,
	input  wire logic [NUM_BUS-1:0]        i_clk,
	input  wire logic [NUM_BUS*WORD_W-1:0] i_data,
	input  wire logic [NUM_BUS-1:0]        i_strobe,
	input  wire logic                      i_sync_n,
	input  wire logic                      i_lsb_reg,
	output logic      [WORD_W-1:0]         o_rise [NUM_BUS],
	output logic      [WORD_W-1:0]         o_fall [NUM_BUS],
	output logic      [15:0]               o_edges [NUM_BUS],
	output logic      [15:0]               o_gap [NUM_BUS]
);
	logic [WORD_W-1:0] mask;
	assign mask = (!i_sync_n || i_lsb_reg) ? (12'h001 << (WORD_W - RES)) : 12'h000;
	for (genvar b = 0; b < NUM_BUS; b++) begin : g_bus
		logic [WORD_W-1:0] w;
		logic [15:0]       last;
		logic [15:0]       wptr;
		logic              strb;
		assign w = i_data[b*WORD_W +: WORD_W];
		assign strb = (mask != 12'h000) ? |(w & mask) : i_strobe[b];
		// Own clock per bus, so skew between buses never matters
		always @(posedge i_clk[b] or posedge i_rst) begin
			if (i_rst) begin
				o_edges[b] <= '0;
				o_gap[b] <= '0;
				last <= '0;
				wptr <= '0;
			end else begin
				o_rise[b] <= w & ~mask;
				o_edges[b] <= o_edges[b] + 16'h0001;
				wptr <= strb ? 16'h0000 : wptr + 16'h0002;
				if (strb) begin
					o_gap[b] <= o_edges[b] + 16'h0001 - last;
					last <= o_edges[b] + 16'h0001;
				end
			end
		end
		always @(negedge i_clk[b]) begin
			o_fall[b] <= w & ~mask;
		end
	end
endmodule

/* sim/hvp_ddr_monitor.sv */
// Concurrent checks on the DDR sample bus driver ports
`timescale 1ns/1ps
module hvp_ddr_monitor
	import hvp_pkg::*;
(
	input wire logic                      i_clk,
	input wire logic                      i_rst,
	input wire logic                      i_re,
	input wire logic [DATA_W-1:0]         o_rdata,
	input wire logic                      i_smp_valid,
	input wire logic                      o_smp_ready,
	input wire logic [NUM_BUS-1:0]        o_bus_clk,
	input wire logic [NUM_BUS*WORD_W-1:0] o_bus_data,
	input wire logic [NUM_BUS-1:0]        o_bus_strobe,
	input wire logic                      o_sync_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	read_idle_a: assert property (!$past(i_re) |-> o_rdata == '0)
		else $error("read data outside answer cycle");
	ready_spacing_a: assert property (o_smp_ready |=> !o_smp_ready [*7])
		else $error("sample ready too close");
	ready_valid_a: assert property (o_smp_ready |-> $past(i_smp_valid))
		else $error("group taken without valid");
	eye_center_a: assert property ($changed(o_bus_data) |-> $stable(o_bus_clk))
		else $error("data moved with clock edge");
	clock_half_a: assert property ($rose(o_bus_clk[0]) |=>
		$stable(o_bus_clk[0]) [*7] ##1 !o_bus_clk[0])
		else $error("bus clock high time wrong");
	strobe_edge_a: assert property ($rose(o_bus_strobe[0]) |->
		##[1:8] ($rose(o_bus_clk[0]) && o_bus_strobe[0]))
		else $error("strobe not on rising edge");
	strobe_pair_a: assert property (o_bus_strobe[0] |-> o_bus_strobe[2])
		else $error("strobes not aligned");
	lsb_quiet_a: assert property (!o_sync_n |-> o_bus_strobe == '0)
		else $error("dedicated strobe in LSB mode");
	guard_zero_a: assert property ($fell(o_sync_n) |=>
		(o_bus_strobe == '0 && !o_bus_data[0]) [*8])
		else $error("strobe line busy in changeover");
endmodule

/* sim/tb_hvp_ddr_source.sv */
// Self-checking bench for the DDR sample bus driver
`timescale 1ns/1ps
module tb_hvp_ddr_source;
	import hvp_pkg::*;
	logic                      i_clk;
	logic                      i_rst;
	logic [ADDR_W-1:0]         i_addr;
	logic [DATA_W-1:0]         i_wdata;
	logic                      i_we;
	logic                      i_re;
	logic [DATA_W-1:0]         o_rdata;
	logic                      i_smp_valid;
	logic [NUM_BUS*WORD_W-1:0] i_smp_data;
	logic                      o_smp_ready;
	logic [NUM_BUS-1:0]        o_bus_clk;
	logic [NUM_BUS*WORD_W-1:0] o_bus_data;
	logic [NUM_BUS-1:0]        o_bus_strobe;
	logic                      o_sync_n;
	logic                      lsb_reg;
	logic [7:0]                grp = 8'h00;
	logic [WORD_W-1:0]         rise [NUM_BUS];
	logic [WORD_W-1:0]         fall [NUM_BUS];
	logic [15:0]               edges [NUM_BUS];
	logic [15:0]               gap [NUM_BUS];
	int                        miscompares = 0;
	int                        total_checks = 0;
	int                        cycles = 0;

	hvp_ddr_source uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_smp_valid(i_smp_valid),
		.i_smp_data(i_smp_data), .o_smp_ready(o_smp_ready), .o_bus_clk(o_bus_clk),
		.o_bus_data(o_bus_data), .o_bus_strobe(o_bus_strobe), .o_sync_n(o_sync_n));
	hvp_rx_model rx (.i_rst(i_rst), .i_clk(o_bus_clk), .i_data(o_bus_data),
		.i_strobe(o_bus_strobe), .i_sync_n(o_sync_n), .i_lsb_reg(lsb_reg), .o_rise(rise),
		.o_fall(fall), .o_edges(edges), .o_gap(gap));

	// Group number and slot are visible in every word; bit 0 stays clear
	function automatic logic [WORD_W-1:0] word(input logic [7:0] g, input logic [1:0] s);
		word = {g, s, 2'b10};
	endfunction
	assign i_smp_data = {word(grp, 2'h3), word(grp, 2'h2), word(grp, 2'h1), word(grp, 2'h0)};

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (o_smp_ready) begin
			grp <= grp + 8'h01;
		end
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
			input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_we <= 1'b1;
		@(posedge i_clk);
		i_we <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
			input logic [DATA_W-1:0] e);
		i_addr <= a;
		i_re <= 1'b1;
		@(posedge i_clk);
		i_re <= 1'b0;
		@(negedge i_clk);
		check(o_rdata & m, e, "register");
		@(posedge i_clk);
	endtask
	task automatic wait_edges(input int n);
		logic [15:0] t;
		t = edges[0] + 16'(n);
		for (int i = 0; i < 40 * n && edges[0] != t; i++) @(posedge i_clk);
		check({16'h0, edges[0]}, {16'h0, t}, "bus clock edges");
	endtask
	task automatic check_pairs(input logic [1:0] m);
		@(negedge o_bus_clk[0]);
		@(posedge i_clk);
		for (int b = 0; b < NUM_BUS; b += 1 + m[0]) begin
			check({20'h0, rise[b]}, {20'h0, word(rise[0][11:4], 2'(b >> m[0]))}, "rise");
			check({20'h0, fall[b]}, {20'h0, word(rise[0][11:4] + 8'h01, 2'(b >> m[0]))}, "fall");
		end
	endtask
	task automatic run_mode(input logic [1:0] m);
		logic [15:0] off_edges;
		wr(REG_PERIOD, 32'h1 + m);
		wr(REG_CTRL, 32'h0000_0c01 | {29'h0, m, 1'b0});
		repeat (40) @(posedge i_clk);
		off_edges = edges[1];
		expect_reg(REG_STATUS, 32'h0000_00f8, (m == 2'h1) ? 32'h0000_0058 : 32'h0000_00f8);
		wait_edges(40);
		check_pairs(m);
		check({16'h0, gap[0]}, 32'h4 + 4 * m, "strobe gap");
		check({16'h0, gap[2]}, 32'h4 + 4 * m, "strobe gap");
		if (m == 2'h1) check({16'h0, edges[1]}, {16'h0, off_edges}, "idle bus");
		wr(REG_CTRL, 32'h0000_0c00);
		repeat (40) @(posedge i_clk);
	endtask

	task automatic check_reset();
		expect_reg(REG_CTRL, 32'hffff_ffff, 32'h0000_0c00);
		expect_reg(REG_PERIOD, 32'hffff_ffff, 32'h0000_0001);
		expect_reg(4'hc, 32'hffff_ffff, 32'h0000_0000);
		check({31'h0, o_sync_n}, 32'h0000_0001, "select pin");
	endtask
	task automatic run_off();
		wr(REG_CTRL, 32'h0000_0c07);
		expect_reg(REG_STATUS, 32'h0000_00f0, 32'h0000_0000);
		repeat (40) @(posedge i_clk);
		check({28'h0, o_bus_clk}, 32'h0000_0000, "bus clocks off");
	endtask
	task automatic run_underrun();
		wr(REG_CTRL, 32'h0000_0c01);
		wait_edges(4);
		i_smp_valid <= 1'b0;
		wait_edges(2);
		i_smp_valid <= 1'b1;
		expect_reg(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wr(REG_STATUS, 32'h0000_0001);
		expect_reg(REG_STATUS, 32'h0000_0001, 32'h0000_0000);
	endtask
	task automatic run_lsb();
		wr(REG_PERIOD, 32'h0000_0002);
		wr(REG_CTRL, 32'h0000_0c09);
		wait_edges(30);
		check({31'h0, o_sync_n}, 32'h0000_0000, "select pin");
		check({16'h0, gap[0]}, 32'h0000_0008, "line strobe gap");
		check_pairs(2'h0);
		lsb_reg <= 1'b1;
		wr(REG_CTRL, 32'h0000_0c19);
		wait_edges(20);
		check({31'h0, o_sync_n}, 32'h0000_0001, "select pin");
		check({16'h0, gap[0]}, 32'h0000_0008, "line strobe gap");
		check_pairs(2'h0);
	endtask

	initial begin
		i_rst = 1'b1;
		i_addr = '0;
		i_wdata = '0;
		i_we = 1'b0;
		i_re = 1'b0;
		i_smp_valid = 1'b1;
		lsb_reg = 1'b0;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		check_reset();
		for (int m = 0; m < 3; m++) run_mode(2'(m));
		run_off();
		run_underrun();
		run_lsb();
		summarize();
	end
endmodule

bind hvp_ddr_source hvp_ddr_monitor mon (.i_clk(i_clk), .i_rst(i_rst), .i_re(i_re),
	.o_rdata(o_rdata), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready),
	.o_bus_clk(o_bus_clk), .o_bus_data(o_bus_data), .o_bus_strobe(o_bus_strobe),
	.o_sync_n(o_sync_n));
